// >>> hdl/fim_feature_regs.sv
// Read-only monitoring feature identification registers behind a simple register access port.
//
// Function
// - Bandwidth-usage feature register reads zero unless monitoring and bandwidth monitoring exist.
// - Bit 31 reports capture copy register and capture-event support for bandwidth monitor.
// - Bit 30 reports long counter, and long capture register when capture exists.
// - Bit 29 picks 44-bit or 63-bit long value; zero without long counter.
// - Bit 28 reports read/write bandwidth selection in the bandwidth filter register.
// - Bits 30 to 28 read zero without the extended architecture revision.
// - Field 20:16 is the scaling right-shift count; zero means no scaling.
// - Field 15:0 is the number of bandwidth monitors; largest selector is count minus one.
// - Per-instance fields follow the partition resource instance selector; others stay constant.
// - Monitor selection register's instance selector never affects bandwidth feature reads.
// - Bandwidth feature register is 32 bits wide and read-only.
// - Both pages are readable; secure and non-secure copies differ where contents differ.
// - Monitoring feature register reads zero unless monitoring is implemented.
// - Bit 31 reports the local capture event generator and its event register.
// - Bit 17 reports bandwidth usage monitoring by partition and monitor group.
// - Bit 16 reports cache storage usage monitoring and its registers.
`timescale 1ns/1ps

module fim_feature_regs (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic acc_secure,
    input wire logic [fim_pkg::ADDR_W-1:0] acc_addr,
    input wire logic [fim_pkg::DATA_W-1:0] acc_wdata,
    input wire logic [fim_pkg::INST_SEL_W-1:0] resource_instance_sel,
    input wire logic [fim_pkg::INST_SEL_W-1:0] monitor_select_instance,
    output logic acc_ready,
    output logic [fim_pkg::DATA_W-1:0] acc_rdata
);

    // ========================================================================
    // Feature word lookup
    // ========================================================================
    logic [fim_pkg::DATA_W-1:0] bw_word;
    logic [fim_pkg::DATA_W-1:0] msmon_word;

    // Only the partition selector reaches the table; the monitor selection
    // register's instance field is deliberately left out of the lookup.
    fim_instance_table u_table (
        .resource_instance_sel(resource_instance_sel),
        .secure(acc_secure),
        .bw_word(bw_word),
        .msmon_word(msmon_word)
    );

    // ========================================================================
    // Access decode
    // ========================================================================
    logic rd_fire;
    logic hit_bw;
    logic hit_ms;
    logic [fim_pkg::DATA_W-1:0] next_rdata;

    // The full word address must match, so unaligned offsets are unmapped.
    assign rd_fire = acc_valid && !acc_write;
    assign hit_bw = (acc_addr == fim_pkg::OFS_BW_USAGE_MON_FEATURES);
    assign hit_ms = (acc_addr == fim_pkg::OFS_MONITORING_FEATURES);

    // Both pages decode the same offsets; the page only picks the copy.
    always_comb
    begin
        next_rdata = fim_pkg::READ_ZERO;
        if (hit_bw)
        begin
            next_rdata = bw_word;
        end
        else if (hit_ms)
        begin
            next_rdata = msmon_word;
        end
    end

    // ========================================================================
    // Read data register
    // ========================================================================
    // Writes never reach the data path, so read data simply holds; the
    // write data port only feeds the checking helpers.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            acc_rdata <= fim_pkg::READ_ZERO;
        end
        else if (rd_fire)
        begin
            acc_rdata <= next_rdata;
        end
    end

    // ========================================================================
    // Access acknowledge
    // ========================================================================
    // Every access, read or ignored write, completes one cycle after it is taken.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            acc_ready <= 1'b0;
        end
        else
        begin
            acc_ready <= acc_valid;
        end
    end

    // ========================================================================
    // Checking helpers
    // ========================================================================
    fim_pkg::fim_read_kind_t last_kind;
    logic [fim_pkg::INST_SEL_W-1:0] last_sel;
    logic last_sec;
    logic wr_seen;
    logic [fim_pkg::DATA_W-1:0] wdata_seen;

    // Remember what the last read asked for, so checks can rebuild the answer
    // from the configuration tables without looking inside the lookup.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            last_kind <= fim_pkg::FIM_READ_NONE;
            last_sel <= '0;
            last_sec <= 1'b0;
        end
        else if (rd_fire)
        begin
            last_kind <= hit_bw ? fim_pkg::FIM_READ_BW : (hit_ms ? fim_pkg::FIM_READ_MS : fim_pkg::FIM_READ_NONE);
            last_sel <= resource_instance_sel;
            last_sec <= acc_secure;
        end
    end

    // Write payload is kept only so the ignored-write cover can see it.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            wr_seen <= 1'b0;
            wdata_seen <= fim_pkg::READ_ZERO;
        end
        else
        begin
            wr_seen <= acc_valid && acc_write;
            wdata_seen <= acc_wdata;
        end
    end

    logic exp_ok;
    logic [fim_pkg::INST_IDX_W-1:0] exp_idx;
    logic exp_bw_present;
    logic exp_long;
    logic [fim_pkg::COUNT_W-1:0] exp_count;
    assign exp_ok = last_sel < fim_pkg::NUM_INST_SEL;
    assign exp_idx = last_sel[fim_pkg::INST_IDX_W-1:0];
    assign exp_bw_present = exp_ok && fim_pkg::MONITORING_PRESENT && fim_pkg::INST_BW_USAGE_MON[exp_idx];
    assign exp_long = exp_bw_present && fim_pkg::EXTENDED_REV_PRESENT && fim_pkg::INST_HAS_LONG[exp_idx];
    assign exp_count = !exp_bw_present ? 16'h0000
                     : last_sec ? fim_pkg::INST_COUNT_SECURE[exp_idx*fim_pkg::COUNT_W +: fim_pkg::COUNT_W]
                                : fim_pkg::INST_COUNT_NONSECURE[exp_idx*fim_pkg::COUNT_W +: fim_pkg::COUNT_W];

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    property p_bw_absent_zero;
        (last_kind == fim_pkg::FIM_READ_BW) && !exp_bw_present |-> acc_rdata == fim_pkg::READ_ZERO;
    endproperty
    a_bw_absent_zero: assert property (p_bw_absent_zero) else $error("absent bandwidth register not zero");

    property p_capture_bit;
        (last_kind == fim_pkg::FIM_READ_BW)
            |-> acc_rdata[fim_pkg::BW_CAPTURE_BIT] == (exp_bw_present && fim_pkg::INST_HAS_CAPTURE[exp_idx]);
    endproperty
    a_capture_bit: assert property (p_capture_bit) else $error("capture bit wrong for instance");

    property p_long_bit;
        (last_kind == fim_pkg::FIM_READ_BW) |-> acc_rdata[fim_pkg::BW_LONG_BIT] == exp_long;
    endproperty
    a_long_bit: assert property (p_long_bit) else $error("long counter bit wrong");

    property p_width_needs_long;
        (last_kind == fim_pkg::FIM_READ_BW) && acc_rdata[fim_pkg::BW_WIDTH_BIT]
            |-> acc_rdata[fim_pkg::BW_LONG_BIT];
    endproperty
    a_width_needs_long: assert property (p_width_needs_long) else $error("width select set without long");

    // The width select must also be set where the instance really has a 63-bit long value.
    property p_width_value;
        (last_kind == fim_pkg::FIM_READ_BW)
            |-> acc_rdata[fim_pkg::BW_WIDTH_BIT] == (exp_long && fim_pkg::INST_LONG_63BIT[exp_idx]);
    endproperty
    a_width_value: assert property (p_width_value) else $error("long width select wrong");

    property p_rwsel_bit;
        (last_kind == fim_pkg::FIM_READ_BW) |-> acc_rdata[fim_pkg::BW_RWSEL_BIT] ==
            (exp_bw_present && fim_pkg::EXTENDED_REV_PRESENT && fim_pkg::INST_RW_SELECT[exp_idx]);
    endproperty
    a_rwsel_bit: assert property (p_rwsel_bit) else $error("read/write select bit wrong");

    property p_ext_rev_gate;
        (last_kind == fim_pkg::FIM_READ_BW) && !fim_pkg::EXTENDED_REV_PRESENT
            |-> acc_rdata[fim_pkg::BW_LONG_BIT:fim_pkg::BW_RWSEL_BIT] == 3'h0;
    endproperty
    a_ext_rev_gate: assert property (p_ext_rev_gate) else $error("revision bits set without revision");

    property p_scale_field;
        (last_kind == fim_pkg::FIM_READ_BW) && exp_bw_present
            |-> acc_rdata[fim_pkg::BW_SCALE_LSB +: fim_pkg::SCALE_W]
                == fim_pkg::INST_SCALE[exp_idx*fim_pkg::SCALE_W +: fim_pkg::SCALE_W];
    endproperty
    a_scale_field: assert property (p_scale_field) else $error("scale field wrong");

    property p_count_field;
        (last_kind == fim_pkg::FIM_READ_BW) |-> acc_rdata[fim_pkg::COUNT_LSB +: fim_pkg::COUNT_W] == exp_count;
    endproperty
    a_count_field: assert property (p_count_field) else $error("monitor count wrong for page");

    property p_reserved_zero;
        (last_kind == fim_pkg::FIM_READ_BW) |-> acc_rdata[27:21] == 7'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

    // Offsets off the two feature words, aligned or not, must answer zero.
    property p_unmapped_zero;
        rd_fire && !hit_bw && !hit_ms
            |=> acc_rdata == fim_pkg::READ_ZERO;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

    // Two back-to-back reads differing only in the monitor selector give the same word.
    property p_monsel_ignored;
        rd_fire && hit_bw ##1 rd_fire && hit_bw && $stable(resource_instance_sel) && $stable(acc_secure)
            && $changed(monitor_select_instance) |=> $stable(acc_rdata);
    endproperty
    a_monsel_ignored: assert property (p_monsel_ignored) else $error("monitor selector changed read data");

    property p_instance_tracks;
        rd_fire && hit_bw && (resource_instance_sel == 4'h1) && acc_secure
            |=> acc_rdata[fim_pkg::COUNT_LSB +: fim_pkg::COUNT_W] == 16'h0001;
    endproperty
    a_instance_tracks: assert property (p_instance_tracks) else $error("count does not follow instance");

    property p_page_copy;
        rd_fire && hit_bw && (resource_instance_sel == 4'h0) && !acc_secure
            |=> acc_rdata[fim_pkg::COUNT_LSB +: fim_pkg::COUNT_W] == 16'h0010;
    endproperty
    a_page_copy: assert property (p_page_copy) else $error("non-secure copy not selected");

    property p_ms_fields;
        (last_kind == fim_pkg::FIM_READ_MS) |-> acc_rdata ==
            (!fim_pkg::MONITORING_PRESENT || !exp_ok ? fim_pkg::READ_ZERO
             : {fim_pkg::LOCAL_CAPTURE_GEN_PRESENT, 13'h0000, fim_pkg::INST_BW_USAGE_MON[exp_idx],
                fim_pkg::INST_CACHE_USAGE_MON[exp_idx], 16'h0000});
    endproperty
    a_ms_fields: assert property (p_ms_fields) else $error("monitoring feature word wrong");

    property p_write_ignored;
        acc_valid && acc_write && !(acc_valid && !acc_write) |=> acc_ready ##0 $stable(acc_rdata);
    endproperty
    a_write_ignored: assert property (p_write_ignored) else $error("write changed read data");

    property p_ack_one_cycle;
        acc_valid |=> acc_ready;
    endproperty
    a_ack_one_cycle: assert property (p_ack_one_cycle) else $error("access not acknowledged next cycle");

    property p_ack_needs_request;
        acc_ready |-> $past(acc_valid);
    endproperty
    a_ack_needs_request: assert property (p_ack_needs_request) else $error("spurious acknowledge");

    // Main scenarios: bandwidth reads on each page, a monitoring read, an ignored write and back-to-back reads.
    c_bw_secure: cover property (rd_fire && hit_bw && acc_secure);
    c_bw_nonsecure: cover property (rd_fire && hit_bw && !acc_secure && (resource_instance_sel == 4'h3));
    c_ms_read: cover property (rd_fire && hit_ms);
    c_write_ignored: cover property (wr_seen && (wdata_seen != fim_pkg::READ_ZERO));
    c_back_to_back: cover property (rd_fire ##1 rd_fire);

endmodule : fim_feature_regs

// >>> hdl/fim_instance_table.sv
// Per-resource-instance feature words for the selected instance and security page.
`timescale 1ns/1ps

module fim_instance_table (
    input wire logic [fim_pkg::INST_SEL_W-1:0] resource_instance_sel,
    input wire logic secure,
    output logic [fim_pkg::DATA_W-1:0] bw_word,
    output logic [fim_pkg::DATA_W-1:0] msmon_word
);

    // ========================================================================
    // Word assembly per instance
    // ========================================================================
    logic [fim_pkg::DATA_W-1:0] inst_bw [fim_pkg::NUM_INST];
    logic [fim_pkg::DATA_W-1:0] inst_ms [fim_pkg::NUM_INST];

    // Each instance gets its own constant words; nothing here is stored.
    genvar gi;
    generate
        for (gi = 0; gi < fim_pkg::NUM_INST; gi = gi + 1)
        begin : g_inst
            logic long_ok;
            logic [fim_pkg::COUNT_W-1:0] count;
            // Long counter fields exist only on the extended revision.
            assign long_ok = fim_pkg::EXTENDED_REV_PRESENT & fim_pkg::INST_HAS_LONG[gi];
            assign count = secure ? fim_pkg::INST_COUNT_SECURE[gi*fim_pkg::COUNT_W +: fim_pkg::COUNT_W]
                                  : fim_pkg::INST_COUNT_NONSECURE[gi*fim_pkg::COUNT_W +: fim_pkg::COUNT_W];
            always_comb
            begin
                inst_bw[gi] = fim_pkg::READ_ZERO;
                inst_bw[gi][fim_pkg::BW_CAPTURE_BIT] = fim_pkg::INST_HAS_CAPTURE[gi];
                inst_bw[gi][fim_pkg::BW_LONG_BIT] = long_ok;
                // Width select is forced low when no long counter exists.
                inst_bw[gi][fim_pkg::BW_WIDTH_BIT] = long_ok & fim_pkg::INST_LONG_63BIT[gi];
                inst_bw[gi][fim_pkg::BW_RWSEL_BIT] = fim_pkg::EXTENDED_REV_PRESENT
                                                     & fim_pkg::INST_RW_SELECT[gi];
                inst_bw[gi][fim_pkg::BW_SCALE_LSB +: fim_pkg::SCALE_W] =
                    fim_pkg::INST_SCALE[gi*fim_pkg::SCALE_W +: fim_pkg::SCALE_W];
                inst_bw[gi][fim_pkg::COUNT_LSB +: fim_pkg::COUNT_W] = count;
                // Register absent on this instance reads as zero.
                if (!(fim_pkg::MONITORING_PRESENT && fim_pkg::INST_BW_USAGE_MON[gi]))
                begin
                    inst_bw[gi] = fim_pkg::READ_ZERO;
                end
                inst_ms[gi] = fim_pkg::READ_ZERO;
                inst_ms[gi][fim_pkg::MS_LOCAL_CAPT_BIT] = fim_pkg::LOCAL_CAPTURE_GEN_PRESENT;
                inst_ms[gi][fim_pkg::MS_BW_USAGE_BIT] = fim_pkg::INST_BW_USAGE_MON[gi];
                inst_ms[gi][fim_pkg::MS_CACHE_USAGE_BIT] = fim_pkg::INST_CACHE_USAGE_MON[gi];
                if (!fim_pkg::MONITORING_PRESENT)
                begin
                    inst_ms[gi] = fim_pkg::READ_ZERO;
                end
            end
        end
    endgenerate

    // ========================================================================
    // Instance selection
    // ========================================================================
    // A selector past the last instance reads as zero rather than aliasing.
    logic [fim_pkg::INST_IDX_W-1:0] idx;
    logic sel_ok;
    assign sel_ok = !fim_pkg::INSTANCE_SELECT_PRESENT || (resource_instance_sel < fim_pkg::NUM_INST_SEL);
    assign idx = fim_pkg::INSTANCE_SELECT_PRESENT ? resource_instance_sel[fim_pkg::INST_IDX_W-1:0]
                                                  : '0;
    assign bw_word = sel_ok ? inst_bw[idx] : fim_pkg::READ_ZERO;
    assign msmon_word = sel_ok ? inst_ms[idx] : fim_pkg::READ_ZERO;

endmodule : fim_instance_table

// >>> hdl/fim_pkg.sv
// Constants and implementation configuration for the monitoring feature identification registers.
package fim_pkg;

    // ========================================================================
    // Register access port geometry and offsets
    // ========================================================================
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_MONITORING_FEATURES = 12'h080;
    localparam logic [ADDR_W-1:0] OFS_BW_USAGE_MON_FEATURES = 12'h090;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

    // ========================================================================
    // Field positions of the bandwidth-usage monitor feature register
    // ========================================================================
    localparam int BW_CAPTURE_BIT = 31;
    localparam int BW_LONG_BIT = 30;
    localparam int BW_WIDTH_BIT = 29;
    localparam int BW_RWSEL_BIT = 28;
    localparam int BW_SCALE_LSB = 16;
    localparam int SCALE_W = 5;
    localparam int COUNT_LSB = 0;
    localparam int COUNT_W = 16;

    // ========================================================================
    // Field positions of the monitoring feature register
    // ========================================================================
    localparam int MS_LOCAL_CAPT_BIT = 31;
    localparam int MS_BW_USAGE_BIT = 17;
    localparam int MS_CACHE_USAGE_BIT = 16;

    // ========================================================================
    // Implementation configuration (fixed at build time)
    // ========================================================================
    localparam int INST_SEL_W = 4;
    localparam int NUM_INST = 4;
    localparam int INST_IDX_W = 2;
    localparam logic [INST_SEL_W-1:0] NUM_INST_SEL = 4'h4;
    localparam logic MONITORING_PRESENT = 1'b1;
    localparam logic INSTANCE_SELECT_PRESENT = 1'b1;
    localparam logic EXTENDED_REV_PRESENT = 1'b1;
    localparam logic LOCAL_CAPTURE_GEN_PRESENT = 1'b1;
    // Per-instance tables, bit i or slice i belongs to resource instance i.
    localparam logic [NUM_INST-1:0] INST_BW_USAGE_MON = 4'hb;
    localparam logic [NUM_INST-1:0] INST_CACHE_USAGE_MON = 4'h5;
    localparam logic [NUM_INST-1:0] INST_HAS_CAPTURE = 4'h3;
    localparam logic [NUM_INST-1:0] INST_HAS_LONG = 4'h9;
    localparam logic [NUM_INST-1:0] INST_LONG_63BIT = 4'h8;
    localparam logic [NUM_INST-1:0] INST_RW_SELECT = 4'ha;
    localparam logic [NUM_INST*SCALE_W-1:0] INST_SCALE = 20'h18820;
    // Secure and non-secure pages report separate monitor counts.
    localparam logic [NUM_INST*COUNT_W-1:0] INST_COUNT_SECURE = 64'h0002_0000_0001_0004;
    localparam logic [NUM_INST*COUNT_W-1:0] INST_COUNT_NONSECURE = 64'h0008_0000_0004_0010;

    // Kind of the last register read, used by checking logic.
    typedef enum logic [1:0] {
        FIM_READ_NONE = 2'b00,
        FIM_READ_BW = 2'b01,
        FIM_READ_MS = 2'b11
    } fim_read_kind_t;

endpackage : fim_pkg

// >>> test/tb_fim_feature_regs.sv
// Self-checking testbench for the monitoring feature identification registers.
`timescale 1ns/1ps

module tb_fim_feature_regs;

    // ========================================================================
    // Clock, reset and design hookup
    // ========================================================================
    logic clk_sys;
    logic reset;
    logic acc_valid;
    logic acc_write;
    logic acc_secure;
    logic [fim_pkg::ADDR_W-1:0] acc_addr;
    logic [fim_pkg::DATA_W-1:0] acc_wdata;
    logic [fim_pkg::INST_SEL_W-1:0] resource_instance_sel;
    logic [fim_pkg::INST_SEL_W-1:0] monitor_select_instance;
    logic acc_ready;
    logic [fim_pkg::DATA_W-1:0] acc_rdata;
    int error_cnt;
    int total_checks;

    fim_feature_regs DUT (
        .clk_sys(clk_sys),
        .reset(reset),
        .acc_valid(acc_valid),
        .acc_write(acc_write),
        .acc_secure(acc_secure),
        .acc_addr(acc_addr),
        .acc_wdata(acc_wdata),
        .resource_instance_sel(resource_instance_sel),
        .monitor_select_instance(monitor_select_instance),
        .acc_ready(acc_ready),
        .acc_rdata(acc_rdata)
    );

    // A 100 ns period gives the 10 MHz system clock.
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ========================================================================
    // Expected words, built field by field from the build configuration
    // ========================================================================
    function automatic logic [31:0] exp_bw(input logic [3:0] sel, input logic sec);
        logic [31:0] w;
        int i;
        w = 32'h0;
        i = sel;
        if (sel < fim_pkg::NUM_INST && fim_pkg::MONITORING_PRESENT && fim_pkg::INST_BW_USAGE_MON[i])
        begin
            w[31] = fim_pkg::INST_HAS_CAPTURE[i];
            w[30] = fim_pkg::INST_HAS_LONG[i] & fim_pkg::EXTENDED_REV_PRESENT;
            w[29] = fim_pkg::INST_LONG_63BIT[i] & w[30];
            w[28] = fim_pkg::INST_RW_SELECT[i] & fim_pkg::EXTENDED_REV_PRESENT;
            w[20:16] = fim_pkg::INST_SCALE[i*fim_pkg::SCALE_W +: fim_pkg::SCALE_W];
            w[15:0] = sec ? fim_pkg::INST_COUNT_SECURE[i*16 +: 16] : fim_pkg::INST_COUNT_NONSECURE[i*16 +: 16];
        end
        return w;
    endfunction : exp_bw

    function automatic logic [31:0] exp_ms(input logic [3:0] sel);
        logic [31:0] w;
        int i;
        w = 32'h0;
        i = sel;
        if (sel < fim_pkg::NUM_INST && fim_pkg::MONITORING_PRESENT)
        begin
            w[31] = fim_pkg::LOCAL_CAPTURE_GEN_PRESENT;
            w[17] = fim_pkg::INST_BW_USAGE_MON[i];
            w[16] = fim_pkg::INST_CACHE_USAGE_MON[i];
        end
        return w;
    endfunction : exp_ms

    // ========================================================================
    // Shared tasks for comparison, single accesses and the verdict
    // ========================================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        total_checks++;
        if (seen !== expected)
        begin
            $display("[ERR] %0t seen %h expected %h", $time, seen, expected);
            error_cnt++;
        end
    endtask : check

    // One access; the answer is looked at in the single cycle that acc_ready stands.
    task automatic access(input logic wr, input logic sec, input logic [11:0] addr, input logic [3:0] sel,
                          input logic [3:0] msel, input logic [31:0] wdata, output logic [31:0] rdata);
        @(posedge clk_sys);
        acc_valid <= 1'b1;
        acc_write <= wr;
        acc_secure <= sec;
        acc_addr <= addr;
        acc_wdata <= wdata;
        resource_instance_sel <= sel;
        monitor_select_instance <= msel;
        @(posedge clk_sys);
        acc_valid <= 1'b0;
        #1;
        check({31'h0, acc_ready}, 32'h1);
        rdata = acc_rdata;
    endtask : access

    task automatic close_out;
        if (error_cnt == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    // ========================================================================
    // Scenarios
    // ========================================================================
    // Selectors 0 to 7, both pages, both registers; selectors past the table read zero.
    task automatic t_read_table;
        logic [31:0] d;
        for (int s = 0; s < 8; s++)
            for (int p = 0; p < 2; p++)
            begin
                access(1'b0, p[0], 12'h090, s[3:0], 4'h0, 32'h0, d);
                check(d, exp_bw(s[3:0], p[0]));
                access(1'b0, p[0], 12'h080, s[3:0], 4'h0, 32'h0, d);
                check(d, exp_ms(s[3:0]));
            end
    endtask : t_read_table

    // The monitor-selection instance field must not steer the bandwidth word.
    task automatic t_monitor_select_ignored;
        logic [31:0] d;
        for (int m = 0; m < 16; m++)
        begin
            access(1'b0, m[0], 12'h090, 4'h3, m[3:0], 32'h0, d);
            check(d, exp_bw(4'h3, m[0]));
        end
    endtask : t_monitor_select_ignored

    // Writes of all ones leave the read data and later reads untouched.
    task automatic t_writes;
        logic [31:0] d;
        access(1'b0, 1'b1, 12'h090, 4'h0, 4'h0, 32'h0, d);
        access(1'b1, 1'b1, 12'h090, 4'h0, 4'h0, 32'hffff_ffff, d);
        check(d, exp_bw(4'h0, 1'b1));
        access(1'b1, 1'b0, 12'h080, 4'h1, 4'h0, 32'hffff_ffff, d);
        check(d, exp_bw(4'h0, 1'b1));
        access(1'b0, 1'b1, 12'h090, 4'h0, 4'h0, 32'h0, d);
        check(d, exp_bw(4'h0, 1'b1));
        access(1'b0, 1'b0, 12'h080, 4'h1, 4'h0, 32'h0, d);
        check(d, exp_ms(4'h1));
        access(1'b0, 1'b0, 12'h094, 4'h0, 4'h0, 32'h0, d);
        check(d, 32'h0);
        access(1'b0, 1'b0, 12'h092, 4'h0, 4'h0, 32'h0, d);
        check(d, 32'h0);
    endtask : t_writes

    // Reads on every edge: the selector walks, then holds while the monitor selector moves.
    task automatic t_back_to_back;
        @(posedge clk_sys);
        acc_valid <= 1'b1;
        acc_write <= 1'b0;
        acc_secure <= 1'b0;
        acc_addr <= 12'h090;
        resource_instance_sel <= 4'h0;
        for (int s = 1; s < 8; s++)
        begin
            @(posedge clk_sys);
            resource_instance_sel <= (s < 5) ? s[3:0] : 4'h3;
            monitor_select_instance <= s[3:0];
            acc_valid <= (s < 7);
            #1;
            check({31'h0, acc_ready}, 32'h1);
            check(acc_rdata, exp_bw((s < 6) ? s[3:0] - 4'h1 : 4'h3, 1'b0));
        end
        @(posedge clk_sys);
    endtask : t_back_to_back

    // A second reset in mid-run clears the answer port.
    task automatic t_mid_reset;
        logic [31:0] d;
        access(1'b0, 1'b1, 12'h080, 4'h0, 4'h0, 32'h0, d);
        check(d, exp_ms(4'h0));
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        check({31'h0, acc_ready}, 32'h0);
        check(acc_rdata, 32'h0);
        @(posedge clk_sys);
        reset <= 1'b0;
    endtask : t_mid_reset

    // ========================================================================
    // Main sequence and watchdog
    // ========================================================================
    initial
    begin
        error_cnt = 0;
        total_checks = 0;
        reset = 1'b1;
        acc_valid = 1'b0;
        acc_write = 1'b0;
        acc_secure = 1'b0;
        acc_addr = 12'h000;
        acc_wdata = 32'h0;
        resource_instance_sel = 4'h0;
        monitor_select_instance = 4'h0;
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        #1;
        check({31'h0, acc_ready}, 32'h0);
        check(acc_rdata, 32'h0);
        t_read_table();
        t_monitor_select_ignored();
        t_writes();
        t_back_to_back();
        t_mid_reset();
        t_read_table();
        close_out();
    end

    // The whole run needs well under a thousand cycles, so this bound only trips on a hang.
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        error_cnt++;
        close_out();
    end

endmodule : tb_fim_feature_regs
